//--- rtl/sdt_timers.v
// Sensor domain timer group with APB registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "sdt_regs.vh"

// Function
// - Three timers; timers 0 and 1 are 16-bit with a power-of-two prescaler.
// - Timers 0 and 1 count clocks or every edge of a chosen tick source.
// - Timers 0 and 1 run once and stop, or restart each period.
// - Timer 2 is 16-bit on 24 MHz, 2 MHz or 32 kHz, free of the processor.
// - Timer 2 has four capture/compare channels, one-shot or periodic.
// - Timer 2 drives processor events, ADC triggers and waveform outputs.
// - The 2 MHz option is the internal medium-speed clock.
// - The 32 kHz option is the 32.768 kHz low-frequency system clock.
module sdt_timers #(
  parameter NCH = 4,
  parameter NSRC = 4
) (
  // Clock and reset
  input  wire            i_ref_clk,
  input  wire            i_rstn,
  // APB slave
  input  wire            i_psel,
  input  wire            i_penable,
  input  wire            i_pwrite,
  input  wire [7:0]      i_paddr,
  input  wire [31:0]     i_pwdata,
  output reg  [31:0]     o_prdata,
  output reg             o_pready,
  output reg             o_pslverr,
  // Clock sources and tick inputs
  input  wire            i_fast_tick,
  input  wire            i_medium_speed_clock,
  input  wire            i_low_frequency_clock,
  input  wire [NSRC-1:0] i_tick_src,
  input  wire [NCH-1:0]  i_capture_in,
  // Events and outputs
  output reg  [6:0]      o_event,
  output reg             o_adc_trigger,
  output reg  [NCH-1:0]  o_wave,
  output reg             o_irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire       acc   = i_psel & i_penable & o_pready;
  wire       wr    = acc & i_pwrite;
  wire       rd    = acc & ~i_pwrite;
  wire [1:0] ch_ix = i_paddr[3:2];

  reg  [11:0] pt_cfg [0:1];
  reg  [15:0] pt_tgt [0:1];
  reg  [3:0]  t2_cfg;
  reg  [15:0] t2_tgt;
  reg  [15:0] t2_cnt;
  reg         t2_run;
  reg         t2_evt;
  reg  [6:0]  irq_status;
  reg  [6:0]  irq_mask;
  reg  [2:0]  adc_sel;
  reg         med_prev;
  reg         low_prev;

  wire [31:0]      pt_cnt;
  wire [1:0]       pt_run;
  wire [1:0]       pt_evt;
  wire [NCH-1:0]   ch_evt;
  wire [NCH*5-1:0] ch_cfg_flat;
  wire [NCH*16-1:0] ch_val_flat;
  wire [6:0]       ev = {ch_evt, t2_evt, pt_evt};

  // ****************************************
  // Prescaled timers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pt
      wire cfg_wr = wr & (i_paddr == (g ? `SDT_T1_CFG : `SDT_T0_CFG));
      wire [1:0] src = pt_cfg[g][`SDT_PT_SRC_HI:`SDT_PT_SRC_LO];
      sdt_ptimer #(
        .W  (16),
        .PW (4)
      ) u_pt (
        .i_ref_clk    (i_ref_clk),
        .i_rstn       (i_rstn),
        .i_start      (cfg_wr & i_pwdata[`SDT_PT_EN]),
        .i_stop       (cfg_wr & ~i_pwdata[`SDT_PT_EN]),
        .i_periodic   (pt_cfg[g][`SDT_PT_PERIODIC]),
        .i_use_tick   (pt_cfg[g][`SDT_PT_USE_TICK]),
        .i_tick_level (i_tick_src[src]),
        .i_prescale   (pt_cfg[g][`SDT_PT_PRE_HI:`SDT_PT_PRE_LO]),
        .i_target     (pt_tgt[g]),
        .o_count      (pt_cnt[g*16 +: 16]),
        .o_running    (pt_run[g]),
        .o_event      (pt_evt[g])
      );
    end
  endgenerate

  // ****************************************
  // Third timer counter
  // ****************************************
  // Fast option arrives as a strobe: 24 MHz cannot be sampled at 20 MHz
  reg t2_tick;
  always @* begin
    case (t2_cfg[`SDT_T2_CLK_HI:`SDT_T2_CLK_LO])
      `SDT_CLK_FAST:   t2_tick = i_fast_tick;
      `SDT_CLK_MEDIUM: t2_tick = i_medium_speed_clock & ~med_prev;
      `SDT_CLK_LOW:    t2_tick = i_low_frequency_clock & ~low_prev;
      default:         t2_tick = 1'b0;
    endcase
  end
  wire t2_step = t2_run & t2_tick;
  wire t2_wr   = wr & (i_paddr == `SDT_T2_CFG);

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      med_prev <= 1'b0;
      low_prev <= 1'b0;
      t2_cnt   <= 16'h0000;
      t2_run   <= 1'b0;
      t2_evt   <= 1'b0;
    end else begin
      med_prev <= i_medium_speed_clock;
      low_prev <= i_low_frequency_clock;
      t2_evt   <= 1'b0;
      if (t2_wr) begin
        t2_run <= i_pwdata[`SDT_T2_EN];
        t2_cnt <= 16'h0000;
      end else if (t2_step) begin
        if (t2_cnt == t2_tgt) begin
          t2_evt <= 1'b1;
          t2_cnt <= 16'h0000;
          t2_run <= t2_cfg[`SDT_T2_PERIODIC];
        end else begin
          t2_cnt <= t2_cnt + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Capture and compare channels
  // ****************************************
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg  [4:0]  cfg;
      reg  [15:0] val;
      reg         armed;
      reg         evt;
      reg         cap_prev;
      wire sel    = (ch_ix == g);
      wire cfg_wr = wr & (i_paddr[7:4] == `SDT_CH_CFG_PAGE) & sel;
      wire val_wr = wr & (i_paddr[7:4] == `SDT_CH_VAL_PAGE) & sel;
      wire cap    = cfg[`SDT_CH_CAPTURE];
      wire hit    = cap ? (i_capture_in[g] & ~cap_prev)
                        : (t2_step & (t2_cnt == val));
      wire [1:0] act = cfg[`SDT_CH_ACT_HI:`SDT_CH_ACT_LO];
      assign ch_evt[g] = evt;
      assign ch_cfg_flat[g*5 +: 5] = cfg;
      assign ch_val_flat[g*16 +: 16] = val;
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cfg      <= `SDT_CH_CFG_RST;
          val      <= `SDT_WORD16_RST;
          armed    <= 1'b0;
          evt      <= 1'b0;
          cap_prev <= 1'b0;
          o_wave[g] <= 1'b0;
        end else begin
          cap_prev <= i_capture_in[g];
          evt      <= 1'b0;
          if (cfg_wr) begin
            cfg   <= i_pwdata[4:0];
            armed <= i_pwdata[`SDT_CH_EN];
          end else if (armed & hit) begin
            evt   <= 1'b1;
            armed <= cfg[`SDT_CH_PERIODIC];
            if (cap)
              val <= t2_cnt;
            else if (act == `SDT_ACT_SET)
              o_wave[g] <= 1'b1;
            else if (act == `SDT_ACT_CLEAR)
              o_wave[g] <= 1'b0;
            else if (act == `SDT_ACT_TOGGLE)
              o_wave[g] <= ~o_wave[g];
          end
          if (val_wr)
            val <= i_pwdata[15:0];
        end
      end
    end
  endgenerate

  // ****************************************
  // Registers, interrupt and event outputs
  // ****************************************
  wire st_rd = rd & (i_paddr == `SDT_IRQ_STATUS);

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pt_cfg[0]     <= `SDT_PT_CFG_RST;
      pt_cfg[1]     <= `SDT_PT_CFG_RST;
      pt_tgt[0]     <= `SDT_WORD16_RST;
      pt_tgt[1]     <= `SDT_WORD16_RST;
      t2_cfg        <= `SDT_T2_CFG_RST;
      t2_tgt        <= `SDT_WORD16_RST;
      irq_status    <= `SDT_IRQ_RST;
      irq_mask      <= `SDT_IRQ_RST;
      adc_sel       <= `SDT_ADC_SEL_RST;
      o_event       <= 7'h00;
      o_adc_trigger <= 1'b0;
      o_irq         <= 1'b0;
    end else begin
      if (wr) begin
        case (i_paddr)
          `SDT_T0_CFG:    pt_cfg[0] <= i_pwdata[11:0];
          `SDT_T1_CFG:    pt_cfg[1] <= i_pwdata[11:0];
          `SDT_T0_TARGET: pt_tgt[0] <= i_pwdata[15:0];
          `SDT_T1_TARGET: pt_tgt[1] <= i_pwdata[15:0];
          `SDT_T2_CFG:    t2_cfg    <= i_pwdata[3:0];
          `SDT_T2_TARGET: t2_tgt    <= i_pwdata[15:0];
          `SDT_IRQ_MASK:  irq_mask  <= i_pwdata[6:0];
          `SDT_ADC_SEL:   adc_sel   <= i_pwdata[2:0];
          default:        adc_sel   <= adc_sel;
        endcase
      end
      // Clear only bits the read returned, so late events survive
      irq_status    <= (irq_status & ~(st_rd ? o_prdata[6:0] : 7'h00)) | ev;
      o_irq         <= |(irq_status & irq_mask);
      o_event       <= ev;
      o_adc_trigger <= (adc_sel < 3'h7) & ev[adc_sel];
    end
  end

  // ****************************************
  // APB answer: one wait state per access
  // ****************************************
  reg [31:0] rdata;
  reg        bad;
  always @* begin
    rdata = 32'h0000_0000;
    bad   = 1'b0;
    if (i_paddr[7:4] == `SDT_CH_CFG_PAGE && i_paddr[3:2] < NCH)
      rdata[4:0] = ch_cfg_flat[ch_ix*5 +: 5];
    else if (i_paddr[7:4] == `SDT_CH_VAL_PAGE && i_paddr[3:2] < NCH)
      rdata[15:0] = ch_val_flat[ch_ix*16 +: 16];
    else begin
      case (i_paddr)
        `SDT_T0_CFG:     rdata[11:0] = pt_cfg[0];
        `SDT_T1_CFG:     rdata[11:0] = pt_cfg[1];
        `SDT_T0_TARGET:  rdata[15:0] = pt_tgt[0];
        `SDT_T1_TARGET:  rdata[15:0] = pt_tgt[1];
        `SDT_T0_COUNT:   rdata[16:0] = {pt_run[0], pt_cnt[15:0]};
        `SDT_T1_COUNT:   rdata[16:0] = {pt_run[1], pt_cnt[31:16]};
        `SDT_T2_CFG:     rdata[3:0]  = t2_cfg;
        `SDT_T2_TARGET:  rdata[15:0] = t2_tgt;
        `SDT_T2_COUNT:   rdata[16:0] = {t2_run, t2_cnt};
        `SDT_IRQ_STATUS: rdata[6:0]  = irq_status;
        `SDT_IRQ_MASK:   rdata[6:0]  = irq_mask;
        `SDT_ADC_SEL:    rdata[2:0]  = adc_sel;
        default:         bad         = 1'b1;
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_prdata  <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ?
                   rdata : 32'h0000_0000;
      o_pslverr <= i_psel & i_penable & ~o_pready & bad;
    end
  end

endmodule

//--- rtl/sdt_regs.vh
// Register map, field positions and reset values of the sensor domain timers
`ifndef SDT_REGS_VH
`define SDT_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SDT_T0_CFG       8'h00
`define SDT_T0_TARGET    8'h04
`define SDT_T1_CFG       8'h08
`define SDT_T1_TARGET    8'h0C
`define SDT_T0_COUNT     8'h10
`define SDT_T1_COUNT     8'h14
`define SDT_T2_CFG       8'h20
`define SDT_T2_TARGET    8'h24
`define SDT_T2_COUNT     8'h28
`define SDT_CH_CFG_PAGE  4'h3
`define SDT_CH_VAL_PAGE  4'h4
`define SDT_IRQ_STATUS   8'h50
`define SDT_IRQ_MASK     8'h54
`define SDT_ADC_SEL      8'h58

// ****************************************
// Prescaled timer configuration fields
// ****************************************
`define SDT_PT_EN        0
`define SDT_PT_PERIODIC  1
`define SDT_PT_USE_TICK  2
`define SDT_PT_SRC_LO    4
`define SDT_PT_SRC_HI    5
`define SDT_PT_PRE_LO    8
`define SDT_PT_PRE_HI    11

// ****************************************
// Third timer configuration fields
// ****************************************
`define SDT_T2_EN        0
`define SDT_T2_CLK_LO    1
`define SDT_T2_CLK_HI    2
`define SDT_T2_PERIODIC  3
`define SDT_CLK_FAST     2'h0
`define SDT_CLK_MEDIUM   2'h1
`define SDT_CLK_LOW      2'h2

// ****************************************
// Channel configuration fields and actions
// ****************************************
`define SDT_CH_EN        0
`define SDT_CH_CAPTURE   1
`define SDT_CH_PERIODIC  2
`define SDT_CH_ACT_LO    3
`define SDT_CH_ACT_HI    4
`define SDT_ACT_SET      2'h0
`define SDT_ACT_CLEAR    2'h1
`define SDT_ACT_TOGGLE   2'h2

// ****************************************
// Reset values
// ****************************************
`define SDT_PT_CFG_RST   12'h000
`define SDT_T2_CFG_RST   4'h0
`define SDT_CH_CFG_RST   5'h00
`define SDT_WORD16_RST   16'hFFFF
`define SDT_IRQ_RST      7'h00
`define SDT_ADC_SEL_RST  3'h2

`endif

//--- rtl/sdt_ptimer.v
// Prescaled 16-bit one-shot or periodic timer
`timescale 1ns/1ps

module sdt_ptimer #(
  parameter W  = 16,
  parameter PW = 4
) (
  // Clock and reset
  input  wire          i_ref_clk,
  input  wire          i_rstn,
  // Control
  input  wire          i_start,
  input  wire          i_stop,
  input  wire          i_periodic,
  input  wire          i_use_tick,
  input  wire          i_tick_level,
  input  wire [PW-1:0] i_prescale,
  input  wire [W-1:0]  i_target,
  // Status
  output reg  [W-1:0]  o_count,
  output reg           o_running,
  output reg           o_event
);

  reg          tick_prev;
  reg  [W-1:0] pre;
  wire [W-1:0] pre_mask = ~({W{1'b1}} << i_prescale);
  wire         tick_edge = i_tick_level ^ tick_prev;
  // Both edges of the tick source count
  wire         step = o_running & (i_use_tick ? tick_edge : 1'b1);

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_prev <= 1'b0;
      pre       <= {W{1'b0}};
      o_count   <= {W{1'b0}};
      o_running <= 1'b0;
      o_event   <= 1'b0;
    end else begin
      tick_prev <= i_tick_level;
      o_event   <= 1'b0;
      if (i_start) begin
        pre       <= {W{1'b0}};
        o_count   <= {W{1'b0}};
        o_running <= 1'b1;
      end else if (i_stop) begin
        o_running <= 1'b0;
      end else if (step) begin
        if (pre == pre_mask) begin
          pre <= {W{1'b0}};
          if (o_count == i_target) begin
            o_event <= 1'b1;
            o_count <= {W{1'b0}};
            if (!i_periodic)
              o_running <= 1'b0;
          end else begin
            o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
          end
        end else begin
          pre <= pre + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

//--- bench/sdt_timers_asserts.sv
// Port checker for the sensor domain timer group
`timescale 1ns/1ps
module sdt_port_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [6:0]  o_event,
  input wire logic        o_adc_trigger,
  input wire logic [3:0]  o_wave,
  input wire logic        o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  AST_PREADY_WAIT: assert property (i_psel && i_penable && !$past(i_penable)
    |-> !o_pready ##1 o_pready) else $error("one wait state expected");
  AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_PRDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_ADC_SAME_EVENT: assert property (o_adc_trigger |-> (|o_event))
    else $error("adc trigger not alongside an event");
  AST_WAVE_WITH_EVENT: assert property ($changed(o_wave) |=>
    (|o_event[6:3])) else $error("waveform moved without channel event");
  AST_ADC_WITH_EVENT: assert property (o_adc_trigger |-> (|o_event) ||
    $past(|o_event)) else $error("adc trigger without event");
  AST_IRQ_RISE: assert property ($rose(o_irq) |-> $past(|o_event) ||
    $past(|o_event, 2) || $past(o_pready) || $past(o_pready, 2))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(o_pready) ||
    $past(o_pready, 2)) else $error("interrupt fell without access");
endmodule
bind sdt_timers sdt_port_chk u_chk (.i_ref_clk, .i_rstn, .i_psel, .i_penable,
  .o_prdata, .o_pready, .o_pslverr, .o_event, .o_adc_trigger, .o_wave,
  .o_irq);

//--- bench/sdt_far_model.sv
// Clock sources and ADC trigger consumer facing the timer group
`timescale 1ns/1ps
module sdt_far_model #(
  parameter int FAST_DIV = 2,
  parameter int MED_HALF = 250,
  // Rounded to whole clock cycles so periods are exact
  parameter int LOW_HALF = 15250
) (
  input  wire logic i_clk,
  input  wire logic i_adc,
  output logic      o_fast,
  output logic      o_med,
  output logic      o_low,
  output int        o_adc_n
);
  int fc = 0;
  initial begin
    o_fast = 1'b0;
    o_med = 1'b0;
    o_low = 1'b0;
    o_adc_n = 0;
  end
  // Free running; edges land on falling edges of the bench clock, never on rising ones
  always #MED_HALF o_med = ~o_med;
  always #LOW_HALF o_low = ~o_low;
  always @(posedge i_clk) begin
    fc <= (fc == FAST_DIV - 1) ? 0 : fc + 1;
    o_fast <= (fc == FAST_DIV - 1);
    if (i_adc === 1'b1) o_adc_n <= o_adc_n + 1;
  end
endmodule

//--- bench/tb.sv
// Self-checking bench of the sensor domain timer group
`timescale 1ns/1ps
`include "sdt_regs.vh"
module tb;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        ton = 1'b0, w0 = 1'b0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [3:0]  tsrc = 4'h0, cap = 4'h0;
  wire  [31:0] prdata;
  wire  [6:0]  ev;
  wire  [3:0]  wave;
  wire         pready, perr, fast, med, low, adc, irq;
  int          err_count, compares, cyc, tc, adc_n, wchg, k, t, n, g, a0;
  int          evn[7];
  int          stp[3] = '{2, 10, 610};
  always #25 clk = ~clk;
  sdt_timers u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .i_fast_tick(fast), .i_medium_speed_clock(med),
    .i_low_frequency_clock(low), .i_tick_src(tsrc), .i_capture_in(cap),
    .o_event(ev), .o_adc_trigger(adc), .o_wave(wave), .o_irq(irq));
  sdt_far_model u_far (.i_clk(clk), .i_adc(adc), .o_fast(fast), .o_med(med),
    .o_low(low), .o_adc_n(adc_n));
  // ****************************************
  // Monitors, tick source and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tc <= (tc == 2) ? 0 : tc + 1;
    tsrc[3:1] <= 3'($urandom);
    if (ton && tc == 2) tsrc[0] <= ~tsrc[0];
    for (int i = 0; i < 7; i++) if (ev[i] === 1'b1) evn[i]++;
    if (wave[0] !== w0) wchg++;
    w0 <= wave[0];
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  function automatic logic near(int a, int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Cycles between two pulses of one event bit
  task gap(input int b, output int p);
    int m;
    m = 0;
    // Skip a pulse left over from the previous setting
    @(posedge clk);
    while (ev[b] !== 1'b1 && m < 5000) begin
      @(posedge clk);
      m++;
    end
    @(posedge clk);
    p = 1;
    while (ev[b] !== 1'b1 && p < 5000) begin
      @(posedge clk);
      p++;
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h0000_9efa));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(0, `SDT_T0_TARGET, 0); chk(rd, 32'h0000_ffff);
    apb(0, `SDT_ADC_SEL, 0); chk(rd, 32'h0000_0002);
    apb(0, 8'h40, 0); chk(rd, 32'h0000_ffff);
    apb(0, 8'hfc, 0); chk(e, 1); chk(rd, 0);
    $display("test reset values done");
    for (k = 0; k < 3; k++) begin
      t = 1 + $urandom % 7;
      n = $urandom % 4;
      apb(1, `SDT_T0_TARGET, t);
      apb(1, `SDT_T0_CFG, (n << 8) | 3);
      gap(0, g); chk(g, (t + 1) << n);
    end
    ton <= 1'b1;
    apb(1, `SDT_T0_TARGET, 3);
    apb(1, `SDT_T0_CFG, 7);
    gap(0, g); chk(g, 12);
    evn[1] = 0;
    apb(1, `SDT_T1_TARGET, 5);
    apb(1, `SDT_T1_CFG, 1);
    repeat (40) @(posedge clk);
    chk(evn[1], 1);
    apb(0, `SDT_T1_COUNT, 0); chk(rd[16], 0);
    $display("test prescaled timers done");
    apb(1, `SDT_IRQ_MASK, 0);
    repeat (30) @(posedge clk);
    chk(irq, 0);
    apb(1, `SDT_IRQ_MASK, 1);
    repeat (30) @(posedge clk);
    chk(irq, 1);
    apb(1, `SDT_T0_CFG, 0);
    apb(0, `SDT_IRQ_STATUS, 0); chk(rd[0], 1);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    $display("test interrupt done");
    apb(1, `SDT_T2_TARGET, 1);
    for (k = 0; k < 3; k++) begin
      apb(1, `SDT_T2_CFG, (k << 1) | 9);
      gap(2, g); chk(g, 2 * stp[k]);
    end
    apb(1, `SDT_T2_CFG, 32'h0000_000b);
    apb(1, 8'h40, 1);
    apb(1, 8'h30, 32'h0000_0015);
    evn[2] = 0;
    evn[3] = 0;
    wchg = 0;
    a0 = adc_n;
    repeat (400) @(posedge clk);
    chk(near(evn[3], evn[2]), 1);
    chk(near(wchg, evn[3]), 1);
    chk(near(adc_n - a0, evn[2]), 1);
    apb(1, 8'h34, 3);
    cap[1] <= 1'b1;
    @(posedge clk) cap[1] <= 1'b0;
    repeat (30) @(posedge clk);
    apb(0, 8'h44, 0); chk(rd <= 1, 1);
    chk(evn[4], 1);
    chk(wave[3:1], 0);
    $display("test third timer done");
    wrap_up;
  end
endmodule
